// ### src/program_sequencer_stack.sv
/*
  program sequencer: instruction cycle phases, program counter, dummy cycles and return stack.
  assumes the decoder drives its exec inputs on this clock and holds them through phase four,
  and that interrupt logic holds its request until acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none

`include "program_sequencer_regs.svh"

module program_sequencer_stack #(
  parameter int PC_WIDTH    = `PC_WIDTH_SMALL,
  parameter int STACK_DEPTH = `STACK_DEPTH_SMALL
) (
  input  wire logic                         core_clk_in,
  input  wire logic                         arst_n_in,
  // register port
  input  wire logic [`REG_ADDR_WIDTH-1:0]   reg_addr_in,
  input  wire logic [`REG_DATA_WIDTH-1:0]   reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [`REG_DATA_WIDTH-1:0]   reg_rdata_out,
  // decoder, sampled at the end of phase four
  input  wire logic                         exec_jump_in,
  input  wire logic                         exec_call_in,
  input  wire logic                         exec_return_in,
  input  wire logic                         exec_skip_in,
  input  wire logic [PC_WIDTH-1:0]          exec_target_in,
  // interrupt logic
  input  wire logic                         irq_request_in,
  input  wire logic [PC_WIDTH-1:0]          irq_vector_in,
  output logic                              irq_ack_out,
  // program memory and phase pins
  output logic      [PC_WIDTH-1:0]          fetch_addr_out,
  output logic                              fetch_strobe_out,
  output logic                              dummy_cycle_out,
  output logic      [`PHASE_COUNT-1:0]      phase_out
);

  // ========================================================================
  // elaboration checks
  if (PC_WIDTH != `PC_WIDTH_SMALL && PC_WIDTH != `PC_WIDTH_LARGE) begin : g_bad_pc
    $error("program_sequencer_stack: unsupported program counter width");
  end
  if (STACK_DEPTH != `STACK_DEPTH_SMALL && STACK_DEPTH != `STACK_DEPTH_LARGE) begin : g_bad_sd
    $error("program_sequencer_stack: unsupported stack depth");
  end

  localparam int HIGH_WIDTH = PC_WIDTH - `PC_LOW_WIDTH;

  // ========================================================================
  // phases
  logic last_phase;

  phase_generator u_phase (
    .core_clk_in      (core_clk_in),
    .arst_n_in        (arst_n_in),
    .phase_out        (),
    .phase_onehot_out (phase_out),
    .last_phase_out   (last_phase)
  );

  // ========================================================================
  // return stack
  logic                stack_push;
  logic                stack_pop;
  logic [PC_WIDTH-1:0] stack_top;
  logic                stack_full;
  logic [PC_WIDTH-1:0] pc_reg;

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_WIDTH)
  ) u_stack (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .push_in     (stack_push),
    .pop_in      (stack_pop),
    .data_in     (pc_reg),
    .top_out     (stack_top),
    .full_out    (stack_full)
  );

  // ========================================================================
  // register decode
  logic pc_low_hit;
  logic pc_low_write;

  assign pc_low_hit   = (reg_addr_in == `PC_LOW_ADDR);
  assign pc_low_write = reg_wr_in && pc_low_hit;

  // ========================================================================
  // pending write to the program counter low byte
  logic                      page_jump_pending_reg;
  logic [`PC_LOW_WIDTH-1:0]  page_jump_data_reg;
  logic                      page_jump_now;
  logic [`PC_LOW_WIDTH-1:0]  page_jump_data;
  logic                      page_jump_taken;

  assign page_jump_now  = page_jump_pending_reg || pc_low_write;
  assign page_jump_data = pc_low_write ? reg_wdata_in : page_jump_data_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_jump_pending_reg <= 1'b0;
    end else if (page_jump_taken) begin
      page_jump_pending_reg <= 1'b0;
    end else if (pc_low_write) begin
      page_jump_pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_jump_data_reg <= '0;
    end else if (pc_low_write) begin
      page_jump_data_reg <= reg_wdata_in;
    end
  end

  // ========================================================================
  // next program counter selection
  logic                             dummy_reg;
  program_sequencer_pkg::pc_source_t pc_source;

  always_comb begin
    pc_source = program_sequencer_pkg::PC_HOLD;
    if (last_phase) begin
      if (dummy_reg) begin
        pc_source = program_sequencer_pkg::PC_FROM_SEQUENCE;
      end else if (exec_return_in) begin
        pc_source = program_sequencer_pkg::PC_FROM_STACK;
      end else if (exec_call_in || exec_jump_in) begin
        pc_source = program_sequencer_pkg::PC_FROM_TARGET;
      end else if (page_jump_now) begin
        pc_source = program_sequencer_pkg::PC_FROM_PAGE;
      end else if (exec_skip_in) begin
        pc_source = program_sequencer_pkg::PC_FROM_SEQUENCE;
      end else if (irq_request_in && !stack_full) begin
        pc_source = program_sequencer_pkg::PC_FROM_VECTOR;
      end else begin
        pc_source = program_sequencer_pkg::PC_FROM_SEQUENCE;
      end
    end
  end

  assign page_jump_taken = (pc_source == program_sequencer_pkg::PC_FROM_PAGE);
  assign stack_pop       = (pc_source == program_sequencer_pkg::PC_FROM_STACK) && !dummy_reg;
  assign stack_push      = !dummy_reg && last_phase &&
                           ((pc_source == program_sequencer_pkg::PC_FROM_TARGET && exec_call_in) ||
                            pc_source == program_sequencer_pkg::PC_FROM_VECTOR);

  // ========================================================================
  // program counter
  logic [PC_WIDTH-1:0] pc_next;

  always_comb begin
    pc_next = pc_reg;
    unique case (pc_source)
      program_sequencer_pkg::PC_FROM_SEQUENCE: pc_next = pc_reg + PC_WIDTH'(`PC_STEP);
      program_sequencer_pkg::PC_FROM_TARGET:   pc_next = exec_target_in;
      program_sequencer_pkg::PC_FROM_STACK:    pc_next = stack_top;
      program_sequencer_pkg::PC_FROM_VECTOR:   pc_next = irq_vector_in;
      program_sequencer_pkg::PC_FROM_PAGE:     pc_next = {pc_reg[PC_WIDTH-1 -: HIGH_WIDTH],
                                                          page_jump_data};
      program_sequencer_pkg::PC_HOLD:          pc_next = pc_reg;
      default:                                 pc_next = pc_reg;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_reg <= PC_WIDTH'(`PC_RESET_VECTOR);
    end else if (last_phase) begin
      pc_reg <= pc_next;
    end
  end

  // ========================================================================
  // dummy cycle marker
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dummy_reg <= 1'b0;
    end else if (last_phase) begin
      dummy_reg <= !dummy_reg &&
                   (pc_source != program_sequencer_pkg::PC_FROM_SEQUENCE || exec_skip_in) &&
                   pc_source != program_sequencer_pkg::PC_HOLD;
    end
  end

  // ========================================================================
  // interrupt acknowledge, withheld while the stack is full
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_ack_out <= 1'b0;
    end else begin
      irq_ack_out <= (pc_source == program_sequencer_pkg::PC_FROM_VECTOR);
    end
  end

  // ========================================================================
  // fetch side outputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fetch_addr_out <= PC_WIDTH'(`PC_RESET_VECTOR);
    end else if (last_phase) begin
      fetch_addr_out <= pc_next;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fetch_strobe_out <= 1'b0;
    end else begin
      fetch_strobe_out <= last_phase;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dummy_cycle_out <= 1'b0;
    end else if (last_phase) begin
      dummy_cycle_out <= !dummy_reg &&
                         (pc_source != program_sequencer_pkg::PC_FROM_SEQUENCE || exec_skip_in);
    end
  end

  // ========================================================================
  // register read, data in the cycle after the strobe only
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= `REG_READ_IDLE;
    end else if (reg_rd_in && pc_low_hit) begin
      reg_rdata_out <= pc_reg[`PC_LOW_WIDTH-1:0];
    end else begin
      reg_rdata_out <= `REG_READ_IDLE;
    end
  end

endmodule // program_sequencer_stack

`default_nettype wire

// ### shared/program_sequencer_regs.svh
/*
  register offsets, widths, reset values and timing counts of the program sequencer.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef PROGRAM_SEQUENCER_REGS_SVH
`define PROGRAM_SEQUENCER_REGS_SVH

// ==========================================================================
// register port
`define REG_ADDR_WIDTH       8
`define REG_DATA_WIDTH       8
`define PC_LOW_ADDR          8'h02
`define REG_READ_IDLE        8'h00

// ==========================================================================
// program counter
`define PC_LOW_WIDTH         8
`define PC_WIDTH_SMALL       10
`define PC_WIDTH_LARGE       11
`define PC_RESET_VECTOR      16'h0000
`define PC_STEP              16'h0001

// ==========================================================================
// return stack
`define STACK_DEPTH_SMALL    4
`define STACK_DEPTH_LARGE    8
`define STACK_DEPTH_MAX      16

// ==========================================================================
// instruction cycle
`define PHASE_COUNT          4

`endif

// ### shared/program_sequencer_pkg.sv
/*
  types shared by the program sequencer modules.
  assumes nothing of its surroundings.
*/
`default_nettype none

package program_sequencer_pkg;

  // ========================================================================
  // phases of one instruction cycle
  typedef enum logic [1:0] {
    PHASE_ONE,
    PHASE_TWO,
    PHASE_THREE,
    PHASE_FOUR
  } phase_t;

  // ========================================================================
  // source of the next program counter value
  typedef enum logic [2:0] {
    PC_FROM_SEQUENCE,
    PC_FROM_TARGET,
    PC_FROM_STACK,
    PC_FROM_VECTOR,
    PC_FROM_PAGE,
    PC_HOLD
  } pc_source_t;

endpackage

`default_nettype wire

// ### src/phase_generator.sv
/*
  splits the system clock into the four phases of an instruction cycle.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

`include "program_sequencer_regs.svh"

module phase_generator (
  input  wire logic                         core_clk_in,
  input  wire logic                         arst_n_in,
  output program_sequencer_pkg::phase_t     phase_out,
  output logic [`PHASE_COUNT-1:0]           phase_onehot_out,
  output logic                              last_phase_out
);

  // ========================================================================
  // phase sequence
  program_sequencer_pkg::phase_t phase_reg;
  program_sequencer_pkg::phase_t phase_next;

  always_comb begin
    unique case (phase_reg)
      program_sequencer_pkg::PHASE_ONE:   phase_next = program_sequencer_pkg::PHASE_TWO;
      program_sequencer_pkg::PHASE_TWO:   phase_next = program_sequencer_pkg::PHASE_THREE;
      program_sequencer_pkg::PHASE_THREE: phase_next = program_sequencer_pkg::PHASE_FOUR;
      program_sequencer_pkg::PHASE_FOUR:  phase_next = program_sequencer_pkg::PHASE_ONE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= program_sequencer_pkg::PHASE_ONE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ========================================================================
  // one-hot copy for the pins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_onehot_out <= `PHASE_COUNT'(1);
    end else begin
      phase_onehot_out <= `PHASE_COUNT'(1) << phase_next;
    end
  end

  assign phase_out      = phase_reg;
  assign last_phase_out = (phase_reg == program_sequencer_pkg::PHASE_FOUR);

endmodule // phase_generator

`default_nettype wire

// ### src/return_stack.sv
/*
  hardware return-address stack held in flip-flops, newest entry at index 0.
  assumes push and pop never come together and at most one per instruction cycle.
*/
`timescale 1ns/100ps
`default_nettype none

`include "program_sequencer_regs.svh"

module return_stack #(
  parameter int DEPTH = `STACK_DEPTH_SMALL,
  parameter int WIDTH = `PC_WIDTH_SMALL
) (
  input  wire logic                         core_clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         push_in,
  input  wire logic                         pop_in,
  input  wire logic [WIDTH-1:0]             data_in,
  output logic      [WIDTH-1:0]             top_out,
  output logic                              full_out
);

  localparam int LEVEL_WIDTH = $clog2(DEPTH + 1);

  if (DEPTH < 2 || DEPTH > `STACK_DEPTH_MAX) begin : g_bad_depth
    $error("return_stack: depth out of range");
  end

  // ========================================================================
  // storage, shifted so that an overflow drops the oldest entry
  logic [WIDTH-1:0]       entry_reg [DEPTH];
  logic [LEVEL_WIDTH-1:0] level_reg;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        entry_reg[i] <= '0;
      end else if (push_in) begin
        entry_reg[i] <= (i == 0) ? data_in : entry_reg[(i == 0) ? 0 : i - 1];
      end else if (pop_in) begin
        entry_reg[i] <= (i == DEPTH - 1) ? entry_reg[i] : entry_reg[(i == DEPTH - 1) ? i : i + 1];
      end
    end
  end

  // ========================================================================
  // stack pointer, level zero (empty) after reset
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_reg <= '0;
    end else if (push_in && level_reg != LEVEL_WIDTH'(DEPTH)) begin
      level_reg <= level_reg + LEVEL_WIDTH'(1);
    end else if (pop_in && level_reg != '0) begin
      level_reg <= level_reg - LEVEL_WIDTH'(1);
    end
  end

  assign top_out  = entry_reg[0];
  assign full_out = (level_reg == LEVEL_WIDTH'(DEPTH));

endmodule // return_stack

`default_nettype wire

// ### tb/seq_props.sv
/*
  concurrent checks on the program sequencer's ports.
  assumes binding to program_sequencer_stack, one clock, async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "program_sequencer_regs.svh"
module seq_props #(
  parameter int PC_WIDTH = `PC_WIDTH_SMALL
) (
  input wire logic                       core_clk_in,
  input wire logic                       arst_n_in,
  input wire logic [`REG_ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic                       reg_rd_in,
  input wire logic [`REG_DATA_WIDTH-1:0] reg_rdata_out,
  input wire logic                       exec_jump_in,
  input wire logic                       exec_return_in,
  input wire logic [PC_WIDTH-1:0]        exec_target_in,
  input wire logic                       irq_request_in,
  input wire logic [PC_WIDTH-1:0]        irq_vector_in,
  input wire logic                       irq_ack_out,
  input wire logic [PC_WIDTH-1:0]        fetch_addr_out,
  input wire logic                       fetch_strobe_out,
  input wire logic                       dummy_cycle_out,
  input wire logic [`PHASE_COUNT-1:0]    phase_out
);
  // ==========================================================================
  // checks start one edge after reset release, when past values are real
  logic run_reg;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= 1'b1;
    end
  end
  // ==========================================================================
  // assertions
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!run_reg);
  phase_ring_a: assert property (
    1'b1 |=> phase_out == {$past(phase_out[2:0]), $past(phase_out[3])})
    else $error("phase ring out of order");
  strobe_phase_a: assert property (
    fetch_strobe_out |-> phase_out == 4'h1 && $past(phase_out) == 4'h8)
    else $error("fetch strobe outside phase one");
  addr_hold_a: assert property (
    !$past(phase_out[3]) |-> $stable(fetch_addr_out))
    else $error("fetch address moved mid cycle");
  dummy_step_a: assert property (
    phase_out[3] && dummy_cycle_out |=>
      fetch_addr_out == PC_WIDTH'($past(fetch_addr_out) + 1) && !dummy_cycle_out)
    else $error("dummy cycle not followed by step");
  jump_load_a: assert property (
    phase_out[3] && !dummy_cycle_out && exec_jump_in && !exec_return_in |=>
      fetch_addr_out == $past(exec_target_in) && dummy_cycle_out)
    else $error("jump target not loaded");
  ack_vector_a: assert property (
    irq_ack_out |-> fetch_addr_out == $past(irq_vector_in) && dummy_cycle_out
      && $past(irq_request_in) && !$past(dummy_cycle_out))
    else $error("interrupt entry wrong");
  ack_pulse_a: assert property (
    irq_ack_out |=> !irq_ack_out [*3])
    else $error("ack longer than one cycle");
  rd_data_a: assert property (
    reg_rd_in && reg_addr_in == `PC_LOW_ADDR |=>
      reg_rdata_out == $past(fetch_addr_out[7:0]))
    else $error("low byte read wrong");
  rd_idle_a: assert property (
    !(reg_rd_in && reg_addr_in == `PC_LOW_ADDR) |=> reg_rdata_out == `REG_READ_IDLE)
    else $error("read data not idle");
  cover property (phase_out[3] && !dummy_cycle_out && exec_jump_in);
  cover property (irq_ack_out);
  cover property (reg_rd_in && reg_addr_in == `PC_LOW_ADDR);
endmodule // seq_props

bind program_sequencer_stack seq_props #(.PC_WIDTH(PC_WIDTH)) u_seq_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .exec_jump_in(exec_jump_in),
  .exec_return_in(exec_return_in), .exec_target_in(exec_target_in),
  .irq_request_in(irq_request_in), .irq_vector_in(irq_vector_in),
  .irq_ack_out(irq_ack_out), .fetch_addr_out(fetch_addr_out),
  .fetch_strobe_out(fetch_strobe_out), .dummy_cycle_out(dummy_cycle_out),
  .phase_out(phase_out));
`default_nettype wire

// ### tb/seq_partner.sv
/*
  decoder and interrupt logic standing beside the sequencer.
  assumes the one-hot phase and ack outputs of the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module seq_partner (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] phase_in,
  input  wire logic [2:0] op_in,
  input  wire logic [9:0] tgt_in,
  input  wire logic       irq_set_in,
  input  wire logic       irq_ack_in,
  output logic            jump_out,
  output logic            call_out,
  output logic            ret_out,
  output logic            skip_out,
  output logic      [9:0] target_out,
  output logic            irq_request_out
);
  logic [2:0] op_reg;
  logic [9:0] tgt_reg;
  // ==========================================================================
  // instruction held from phase three through phase four
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_reg  <= 3'h0;
      tgt_reg <= 10'h000;
    end else if (phase_in[1]) begin
      op_reg  <= op_in;
      tgt_reg <= tgt_in;
    end else if (phase_in[3]) begin
      op_reg <= 3'h0;
    end
  end
  assign jump_out   = op_reg == 3'h1;
  assign call_out   = op_reg == 3'h2;
  assign ret_out    = op_reg == 3'h3;
  assign skip_out   = op_reg == 3'h4;
  assign target_out = (jump_out || call_out) ? tgt_reg : ~tgt_reg;
  // request held until acknowledged
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) irq_request_out <= 1'b0;
    else if (irq_ack_in) irq_request_out <= 1'b0;
    else if (irq_set_in) irq_request_out <= 1'b1;
  end
endmodule // seq_partner
`default_nettype wire

// ### tb/tb_top.sv
/*
  self-checking bench for the program sequencer.
  assumes the partner model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "program_sequencer_regs.svh"
module tb_top;
  localparam logic [2:0] op_nop = 3'h0, op_jmp = 3'h1, op_call = 3'h2;
  localparam logic [2:0] op_ret = 3'h3, op_skip = 3'h4;
  logic       core_clk_in, arst_n_in, reg_wr, reg_rd, irq_set, irq_req, irq_ack;
  logic       jump, call, ret, skip, strobe, dummy;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [9:0] tgt, target, faddr, cur;
  logic [9:0] rets [4];
  logic [2:0] op;
  logic [3:0] phase;
  int         err_total, cmp_count, ack_cnt;

  program_sequencer_stack #(.PC_WIDTH(10), .STACK_DEPTH(4)) u_program_sequencer_stack (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .exec_jump_in(jump), .exec_call_in(call),
    .exec_return_in(ret), .exec_skip_in(skip), .exec_target_in(target),
    .irq_request_in(irq_req), .irq_vector_in(10'h300), .irq_ack_out(irq_ack),
    .fetch_addr_out(faddr), .fetch_strobe_out(strobe), .dummy_cycle_out(dummy),
    .phase_out(phase));
  seq_partner u_seq_partner (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .phase_in(phase), .op_in(op),
    .tgt_in(tgt), .irq_set_in(irq_set), .irq_ack_in(irq_ack), .jump_out(jump),
    .call_out(call), .ret_out(ret), .skip_out(skip), .target_out(target),
    .irq_request_out(irq_req));

  // ==========================================================================
  // tasks
  task automatic check(input string what, input logic [9:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // wait for a fetch, check it, then command the instruction now executing
  task automatic ic(input logic [2:0] o, input logic [9:0] t, ea, input logic ed);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 16);
    if (strobe !== 1'b1) begin
      err_total++;
      conclude();
    end
    check("fetch_addr", faddr, ea);
    check("dummy", dummy, ed);
    @(posedge core_clk_in);
    op  <= o;
    tgt <= t;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1;
    check("rdata", rdata, e);
  endtask
  task automatic pulse_irq;
    @(posedge core_clk_in);
    irq_set <= 1'b1;
    @(posedge core_clk_in);
    irq_set <= 1'b0;
  endtask

  always @(negedge core_clk_in) if (irq_ack === 1'b1) ack_cnt++;
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ==========================================================================
  // main sequence
  initial begin
    {arst_n_in, reg_wr, reg_rd, irq_set, reg_addr, reg_wdata, op, tgt} = '0;
    {err_total, cmp_count, ack_cnt} = '0;
    rets = '{10'h232, 10'h221, 10'h211, 10'h201};
    repeat (20) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    ic(op_nop, 10'h000, 10'h001, 1'b0);
    ic(op_jmp, 10'h155, 10'h002, 1'b0);
    ic(op_jmp, 10'h0AA, 10'h155, 1'b1);
    ic(op_skip, 10'h000, 10'h156, 1'b0);
    ic(op_nop, 10'h000, 10'h157, 1'b1);
    cur = 10'h158;
    for (int i = 0; i < 5; i++) begin
      ic(op_call, 10'h200 + 10'(i * 16), cur, 1'b0);
      cur = 10'h200 + 10'(i * 16);
      ic(op_nop, 10'h000, cur, 1'b1);
      cur = cur + 10'h001;
    end
    pulse_irq();
    ic(op_nop, 10'h000, 10'h241, 1'b0);
    ic(op_ret, 10'h000, 10'h242, 1'b0);
    ic(op_nop, 10'h000, 10'h231, 1'b1);
    check("ack_held", 10'(ack_cnt), 10'h000);
    ic(op_nop, 10'h000, 10'h232, 1'b0);
    ic(op_nop, 10'h000, 10'h300, 1'b1);
    check("ack_once", 10'(ack_cnt), 10'h001);
    cur = 10'h301;
    for (int k = 0; k < 4; k++) begin
      ic(op_ret, 10'h000, cur, 1'b0);
      ic(op_nop, 10'h000, rets[k], 1'b1);
      cur = rets[k] + 10'h001;
    end
    ic(op_nop, 10'h000, 10'h202, 1'b0);
    rd(`PC_LOW_ADDR, 8'h02);
    rd(8'h03, `REG_READ_IDLE);
    ic(op_nop, 10'h000, 10'h204, 1'b0);
    wr(`PC_LOW_ADDR, 8'h80);
    ic(op_nop, 10'h000, 10'h280, 1'b1);
    ic(op_nop, 10'h000, 10'h281, 1'b0);
    wr(8'h05, 8'h11);
    ic(op_nop, 10'h000, 10'h282, 1'b0);
    rd(`PC_LOW_ADDR, 8'h82);
    // fill the stack so that reset must empty it again
    cur = 10'h283;
    for (int j = 0; j < 4; j++) begin
      ic(op_call, 10'h100, cur, 1'b0);
      ic(op_nop, 10'h000, 10'h100, 1'b1);
      cur = 10'h101;
    end
    @(posedge core_clk_in);
    arst_n_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    check("rst_addr", faddr, 10'h000);
    check("rst_phase", 10'(phase), 10'h001);
    repeat (2) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    ic(op_nop, 10'h000, 10'h001, 1'b0);
    pulse_irq();
    ic(op_nop, 10'h000, 10'h300, 1'b1);
    check("ack_after_rst", 10'(ack_cnt), 10'h002);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
